// >>> rtl/sfb_pkg.sv
// Contract
// - shared core registers decode identically in both banks
// - program counter high byte never directly accessible
// - high latch only holds; copied on counter load
// - separate reset values for power-on and other resets
// - unchanged bits keep, conditional bits follow cause
// - unimplemented addresses and bits read zero
package sfb_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// register indices, byte address is four times the index
	localparam logic [6:0] IDX_INDIRECT = 7'h00;
	localparam logic [6:0] IDX_TIMER0 = 7'h01;
	localparam logic [6:0] IDX_PCL = 7'h02;
	localparam logic [6:0] IDX_STATUS = 7'h03;
	localparam logic [6:0] IDX_POINTER = 7'h04;
	localparam logic [6:0] IDX_PORT_A = 7'h05;
	localparam logic [6:0] IDX_PORT_B = 7'h06;
	localparam logic [6:0] IDX_PORT_C = 7'h07;
	localparam logic [6:0] IDX_PC_HIGH_LATCH = 7'h0a;
	localparam logic [6:0] IDX_INTERRUPT_CONTROL = 7'h0b;
	localparam logic [6:0] IDX_PIR = 7'h0c;
	localparam logic [6:0] IDX_TMR1_LO = 7'h0e;
	localparam logic [6:0] IDX_TMR1_HI = 7'h0f;
	localparam logic [6:0] IDX_T1_CTRL = 7'h10;
	localparam logic [6:0] IDX_TIMER2 = 7'h11;
	localparam logic [6:0] IDX_T2_CTRL = 7'h12;
	localparam logic [6:0] IDX_SSP_BUF = 7'h13;
	localparam logic [6:0] IDX_SSP_CTRL = 7'h14;
	localparam logic [6:0] IDX_CCP_LO = 7'h15;
	localparam logic [6:0] IDX_CCP_HI = 7'h16;
	localparam logic [6:0] IDX_CCP_CTRL = 7'h17;
	localparam logic [6:0] IDX_GAP_LO = 7'h18;
	localparam logic [6:0] IDX_GAP_HI = 7'h1f;
	localparam logic [6:0] IDX_GP_LO = 7'h20;
	localparam logic [6:0] IDX_GP_HI = 7'h7f;

	// field widths
	localparam int unsigned PORT_A_DATA_W = 6;
	localparam int unsigned PC_HIGH_LATCH_W = 5;
	localparam int unsigned PC_W = 13;
	localparam int unsigned TIMER1_CONTROL_W = 6;
	localparam int unsigned TIMER2_CONTROL_W = 7;
	localparam int unsigned CCPCON_W = 6;

	// status bit positions
	localparam int unsigned ST_IRP = 7;
	localparam int unsigned ST_RP1 = 6;
	localparam int unsigned ST_RP0 = 5;
	localparam int unsigned ST_TO = 4;
	localparam int unsigned ST_PD = 3;

	// reset values and masks
	localparam logic [7:0] STATUS_POR = 8'h18;
	localparam logic [7:0] STATUS_WMASK = 8'he7;
	localparam logic [7:0] STATUS_KEEP_OTHER = 8'h07;
	localparam logic [7:0] INTERRUPT_CONTROL_KEEP_OTHER = 8'h01;
	localparam logic [7:0] ZERO8 = 8'h00;

	typedef enum logic {
		PH_IDLE,
		PH_READY
	} sfb_phase_type;

	typedef struct packed {
		logic [PORT_A_DATA_W-1:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} sfb_port_type;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] indirect_pointer;
		logic [7:0] interrupt_control;
		logic [7:0] pir;
		logic [TIMER1_CONTROL_W-1:0] timer1_control;
		logic [TIMER2_CONTROL_W-1:0] timer2_control;
		logic [7:0] serial_port_control;
		logic [CCPCON_W-1:0] ccpcon;
	} sfb_ctrl_type;

endpackage

// >>> rtl/sfb_bank0.sv
// The implementer's own choice: the APB interface to the registers.
module sfb_bank0 import sfb_pkg::*; #(
	parameter int unsigned GP_WORDS = 96
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic master_clear_input,
	input wire logic wdt_timeout,
	input wire logic pc_step,
	input wire sfb_port_type port_pins,
	output sfb_port_type port_latch,
	output logic [PC_W-1:0] program_counter,
	output sfb_ctrl_type ctrl
);

	typedef struct packed {
		sfb_phase_type phase;
		logic [DATA_W-1:0] rdata;
		logic [7:0] status;
		logic [7:0] indirect_pointer;
		logic [7:0] interrupt_control;
		logic [7:0] pir;
		logic [7:0] timer0_count;
		logic [7:0] timer1_count_low;
		logic [7:0] timer1_count_high;
		logic [7:0] timer2_count;
		logic [7:0] serial_port_buffer;
		logic [7:0] serial_port_control;
		logic [7:0] ccprl;
		logic [7:0] ccprh;
		logic [PC_HIGH_LATCH_W-1:0] pc_high_latch;
		logic [PC_W-1:0] pc;
		logic [PORT_A_DATA_W-1:0] lat_a;
		logic [7:0] lat_b;
		logic [7:0] lat_c;
		logic [TIMER1_CONTROL_W-1:0] timer1_control;
		logic [TIMER2_CONTROL_W-1:0] timer2_control;
		logic [CCPCON_W-1:0] ccpcon;
	} sfb_state_type;

	sfb_state_type s_q;
	sfb_state_type s_d;

	// general purpose data memory behind the register block
	logic [7:0] ram [0:GP_WORDS-1];
	logic ram_we;
	logic [6:0] ram_addr;

	logic [6:0] dir_idx;
	logic in_range;
	logic tgt_bank;
	logic [6:0] tgt_idx;
	logic shared;
	logic is_gp;
	logic hit;
	logic [7:0] rd_val;
	logic wr_fire;
	logic other_rst;
	logic pcl_wr;

	// address decode, indirect redirection and bank selection
	always_comb begin
		dir_idx = paddr[8:2];
		in_range = (paddr[ADDR_W-1:9] == '0) && (paddr[1:0] == 2'b00);
		if (dir_idx == IDX_INDIRECT) begin
			tgt_bank = s_q.indirect_pointer[7];
			tgt_idx = s_q.indirect_pointer[6:0];
		end else begin
			tgt_bank = s_q.status[ST_RP0];
			tgt_idx = dir_idx;
		end
		shared = (tgt_idx == IDX_INDIRECT) || (tgt_idx == IDX_PCL) ||
			(tgt_idx == IDX_STATUS) || (tgt_idx == IDX_POINTER) ||
			(tgt_idx == IDX_PC_HIGH_LATCH) || (tgt_idx == IDX_INTERRUPT_CONTROL);
		is_gp = (tgt_idx >= IDX_GP_LO) && (tgt_idx <= IDX_GP_HI) &&
			(32'(tgt_idx - IDX_GP_LO) < GP_WORDS);
		// shared registers answer in both banks, the rest only in bank 0
		hit = in_range && (!tgt_bank || shared);
		ram_addr = tgt_idx - IDX_GP_LO;
	end

	// read multiplexer, anything not decoded reads zero
	always_comb begin
		rd_val = ZERO8;
		if (hit) begin
			case (tgt_idx)
				IDX_TIMER0: rd_val = s_q.timer0_count;
				IDX_PCL: rd_val = s_q.pc[7:0];
				IDX_STATUS: rd_val = s_q.status;
				IDX_POINTER: rd_val = s_q.indirect_pointer;
				IDX_PORT_A: rd_val = {2'b00, port_pins.a};
				IDX_PORT_B: rd_val = port_pins.b;
				IDX_PORT_C: rd_val = port_pins.c;
				IDX_PC_HIGH_LATCH: rd_val = {3'b000, s_q.pc_high_latch};
				IDX_INTERRUPT_CONTROL: rd_val = s_q.interrupt_control;
				IDX_PIR: rd_val = s_q.pir;
				IDX_TMR1_LO: rd_val = s_q.timer1_count_low;
				IDX_TMR1_HI: rd_val = s_q.timer1_count_high;
				IDX_T1_CTRL: rd_val = {2'b00, s_q.timer1_control};
				IDX_TIMER2: rd_val = s_q.timer2_count;
				IDX_T2_CTRL: rd_val = {1'b0, s_q.timer2_control};
				IDX_SSP_BUF: rd_val = s_q.serial_port_buffer;
				IDX_SSP_CTRL: rd_val = s_q.serial_port_control;
				IDX_CCP_LO: rd_val = s_q.ccprl;
				IDX_CCP_HI: rd_val = s_q.ccprh;
				IDX_CCP_CTRL: rd_val = {2'b00, s_q.ccpcon};
				default: begin
					if (is_gp && !tgt_bank) begin
						rd_val = ram[ram_addr];
					end
				end
			endcase
		end
	end

	// bus handshake: one wait state, then a registered answer
	assign pready = psel && penable && (s_q.phase == PH_READY);
	assign pslverr = pready && !in_range;
	assign prdata = s_q.rdata;
	assign wr_fire = pready && pwrite;
	assign other_rst = master_clear_input || wdt_timeout;
	assign pcl_wr = wr_fire && hit && (tgt_idx == IDX_PCL) && !other_rst;

	// next state of the whole register bank
	always_comb begin
		s_d = s_q;
		ram_we = 1'b0;
		case (s_q.phase)
			PH_IDLE: begin
				if (psel && penable) begin
					s_d.phase = PH_READY;
					s_d.rdata = {{(DATA_W-8){1'b0}}, rd_val};
				end
			end
			PH_READY: begin
				s_d.phase = PH_IDLE;
			end
			default: begin
				s_d.phase = PH_IDLE;
			end
		endcase
		if (pc_step) begin
			s_d.pc = s_q.pc + 13'h0001;
		end
		if (wr_fire && hit) begin
			case (tgt_idx)
				IDX_TIMER0: s_d.timer0_count = pwdata[7:0];
				// counter load pulls the upper bits from the latch
				IDX_PCL: s_d.pc = {s_q.pc_high_latch, pwdata[7:0]};
				IDX_STATUS: s_d.status = (pwdata[7:0] & STATUS_WMASK) |
					(s_q.status & ~STATUS_WMASK);
				IDX_POINTER: s_d.indirect_pointer = pwdata[7:0];
				IDX_PORT_A: s_d.lat_a = pwdata[PORT_A_DATA_W-1:0];
				IDX_PORT_B: s_d.lat_b = pwdata[7:0];
				IDX_PORT_C: s_d.lat_c = pwdata[7:0];
				IDX_PC_HIGH_LATCH: s_d.pc_high_latch = pwdata[PC_HIGH_LATCH_W-1:0];
				IDX_INTERRUPT_CONTROL: s_d.interrupt_control = pwdata[7:0];
				IDX_PIR: s_d.pir = pwdata[7:0];
				IDX_TMR1_LO: s_d.timer1_count_low = pwdata[7:0];
				IDX_TMR1_HI: s_d.timer1_count_high = pwdata[7:0];
				IDX_T1_CTRL: s_d.timer1_control = pwdata[TIMER1_CONTROL_W-1:0];
				IDX_TIMER2: s_d.timer2_count = pwdata[7:0];
				IDX_T2_CTRL: s_d.timer2_control = pwdata[TIMER2_CONTROL_W-1:0];
				IDX_SSP_BUF: s_d.serial_port_buffer = pwdata[7:0];
				IDX_SSP_CTRL: s_d.serial_port_control = pwdata[7:0];
				IDX_CCP_LO: s_d.ccprl = pwdata[7:0];
				IDX_CCP_HI: s_d.ccprh = pwdata[7:0];
				IDX_CCP_CTRL: s_d.ccpcon = pwdata[CCPCON_W-1:0];
				default: begin
					ram_we = is_gp && !tgt_bank;
				end
			endcase
		end
		// master clear or watchdog: the non power-up value set
		if (other_rst) begin
			ram_we = 1'b0;
			s_d.pc = '0;
			s_d.pc_high_latch = '0;
			s_d.status = s_q.status & STATUS_KEEP_OTHER;
			s_d.status[ST_TO] = s_q.status[ST_TO];
			s_d.status[ST_PD] = s_q.status[ST_PD];
			if (wdt_timeout) begin
				s_d.status[ST_TO] = 1'b0;
				s_d.status[ST_PD] = 1'b1;
			end
			s_d.interrupt_control = s_q.interrupt_control & INTERRUPT_CONTROL_KEEP_OTHER;
			s_d.pir = ZERO8;
			s_d.timer2_count = ZERO8;
			s_d.timer2_control = '0;
			s_d.serial_port_control = ZERO8;
			s_d.ccpcon = '0;
		end
	end

	// state register, power-on values on the asynchronous reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.phase <= PH_IDLE;
			s_q.status <= STATUS_POR;
		end else begin
			s_q <= s_d;
		end
	end

	// data memory holds no reset value
	always_ff @(posedge pclk) begin
		if (ram_we) begin
			ram[ram_addr] <= pwdata[7:0];
		end
	end

	// outputs straight from the state register
	assign port_latch.a = s_q.lat_a;
	assign port_latch.b = s_q.lat_b;
	assign port_latch.c = s_q.lat_c;
	assign program_counter = s_q.pc;
	assign ctrl.status = s_q.status;
	assign ctrl.indirect_pointer = s_q.indirect_pointer;
	assign ctrl.interrupt_control = s_q.interrupt_control;
	assign ctrl.pir = s_q.pir;
	assign ctrl.timer1_control = s_q.timer1_control;
	assign ctrl.timer2_control = s_q.timer2_control;
	assign ctrl.serial_port_control = s_q.serial_port_control;
	assign ctrl.ccpcon = s_q.ccpcon;

	// checks on decode, reset classes and redirection
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_shared_decode: assert property (
		pready && !pwrite && in_range && (dir_idx == IDX_POINTER)
		|-> prdata[7:0] == s_q.indirect_pointer)
	else $error("pointer read differs between banks");

	chk_pc_high_hidden: assert property (
		(s_q.pc[12:8] != $past(s_q.pc[12:8]))
		|-> $past(pcl_wr || pc_step || other_rst))
	else $error("upper counter bits changed without a load");

	chk_pc_high_load: assert property (
		pcl_wr |=> s_q.pc == {$past(s_q.pc_high_latch), $past(pwdata[7:0])})
	else $error("counter load did not take the high latch");

	chk_wdt_cause: assert property (
		wdt_timeout |=> !s_q.status[ST_TO] && s_q.status[ST_PD] && (s_q.pc == '0))
	else $error("watchdog reset values wrong");

	chk_master_clear_input_cause: assert property (
		master_clear_input && !wdt_timeout
		|=> s_q.status[ST_TO:ST_PD] == $past(s_q.status[ST_TO:ST_PD]))
	else $error("master clear altered timeout flags");

	chk_other_keep: assert property (
		other_rst |=> (s_q.timer1_control == $past(s_q.timer1_control)) &&
		(s_q.interrupt_control == ($past(s_q.interrupt_control) & INTERRUPT_CONTROL_KEEP_OTHER)) &&
		(s_q.status[7:5] == 3'b000) && (s_q.indirect_pointer == $past(s_q.indirect_pointer)))
	else $error("other reset lost an unchanged bit");

	chk_gap_zero: assert property (
		pready && !pwrite && in_range && (dir_idx >= IDX_GAP_LO) &&
		(dir_idx <= IDX_GAP_HI) |-> prdata == '0)
	else $error("unimplemented address read nonzero");

	chk_upper_zero: assert property (
		pready |-> prdata[DATA_W-1:8] == '0)
	else $error("bits above the byte read nonzero");

	chk_indirect_write: assert property (
		pready && pwrite && in_range && (dir_idx == IDX_INDIRECT) &&
		(s_q.indirect_pointer == {1'b0, IDX_PC_HIGH_LATCH}) && !other_rst
		|=> s_q.pc_high_latch == $past(pwdata[PC_HIGH_LATCH_W-1:0]))
	else $error("indirect write missed its target");

	chk_port_read: assert property (
		pready && !pwrite && in_range && (dir_idx == IDX_PORT_B) && !s_q.status[ST_RP0]
		|-> prdata[7:0] == $past(port_pins.b))
	else $error("port read did not return pin levels");

	chk_port_write: assert property (
		pready && pwrite && in_range && (dir_idx == IDX_PORT_C) &&
		!s_q.status[ST_RP0] && !other_rst
		|=> port_latch.c == $past(pwdata[7:0]))
	else $error("port write did not reach the latch");

	cov_indirect_ram: cover property (
		pready && !pwrite && (dir_idx == IDX_INDIRECT) && is_gp);
	cov_pcl_load: cover property (pcl_wr ##1 pc_step);
	cov_wdt_reset: cover property (wdt_timeout ##1 pready);
	cov_bank1_shared: cover property (pready && s_q.status[ST_RP0] && shared);

endmodule

// >>> verification/sfb_bank0_test.sv
module sfb_bank0_test;
	import sfb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic master_clear_input = 1'b0;
	logic wdt_timeout = 1'b0;
	logic pc_step = 1'b0;
	sfb_port_type port_pins = '0;
	sfb_port_type port_latch;
	logic [PC_W-1:0] program_counter;
	sfb_ctrl_type ctrl;
	logic [32:0] exp_q[$];
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] v;
	logic [7:0] m;

	sfb_bank0 u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .master_clear_input(master_clear_input),
		.wdt_timeout(wdt_timeout), .pc_step(pc_step), .port_pins(port_pins),
		.port_latch(port_latch), .program_counter(program_counter), .ctrl(ctrl)
	);

	// free-running bus clock
	always #2.5 pclk = ~pclk;

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// compare of a finished read: error flag and data
	task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// compare of a value seen directly on an output port
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer, request held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
			input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		if (!w)
			exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		// request stands until pready is sampled high at a rising edge
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		xfer(1'b1, {3'h0, i, 2'h0}, d, '0);
	endtask

	task automatic rd(input logic [6:0] i, input logic [7:0] e);
		xfer(1'b0, {3'h0, i, 2'h0}, 8'h00, {9'h0, 16'h0, e});
	endtask

	// one-cycle pulse: 0 master clear, 1 watchdog, 2 counter step
	task automatic pulse(input int w);
		@(posedge pclk);
		master_clear_input <= (w == 0);
		wdt_timeout <= (w == 1);
		pc_step <= (w == 2);
		@(posedge pclk);
		master_clear_input <= 1'b0;
		wdt_timeout <= 1'b0;
		pc_step <= 1'b0;
	endtask

	// monitor: each completed read takes the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
			cmp_rd({pslverr, prdata}, exp_q.pop_front());
	end

	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			summarize;
		end
	end

	initial begin
		v = 8'($urandom(36));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_STATUS, 8'h18);
		rd(IDX_INTERRUPT_CONTROL, 8'h00);
		rd(IDX_PC_HIGH_LATCH, 8'h00);
		$display("test reset values done");
		for (int i = 8; i < 32; i++) begin
			if (i == 8 || i == 9 || i == 13 || i >= 24) begin
				wr(7'(i), 8'hff);
				rd(7'(i), 8'h00);
			end
		end
		wr(IDX_T2_CTRL, 8'hff);
		rd(IDX_T2_CTRL, 8'h7f);
		xfer(1'b0, 12'h800, 8'h00, {1'b1, 32'h0});
		$display("test unimplemented space done");
		wr(IDX_PC_HIGH_LATCH, 8'hf5);
		rd(IDX_PC_HIGH_LATCH, 8'h15);
		wr(IDX_PCL, 8'ha5);
		@(negedge pclk);
		cmp_val(32'(program_counter), 32'h15a5);
		rd(IDX_PCL, 8'ha5);
		pulse(2);
		@(negedge pclk);
		cmp_val(32'(program_counter), 32'h15a6);
		$display("test program counter done");
		v = 8'($urandom);
		wr(IDX_TIMER0, 8'h77);
		wr(IDX_POINTER, 8'h25);
		wr(IDX_INDIRECT, v);
		rd(7'h25, v);
		rd(IDX_INDIRECT, v);
		// bank 1 selected through RP0, shared registers still answer, timer 0 reads zero
		wr(IDX_STATUS, 8'h20);
		rd(IDX_PC_HIGH_LATCH, 8'h15);
		rd(IDX_POINTER, 8'h25);
		rd(IDX_INDIRECT, v);
		rd(IDX_TIMER0, 8'h00);
		wr(IDX_STATUS, 8'h07);
		rd(IDX_STATUS, 8'h1f);
		rd(IDX_TIMER0, 8'h77);
		$display("test indirect and banks done");
		port_pins <= sfb_port_type'(22'($urandom));
		for (int k = 0; k < 3; k++) begin
			m = (k == 0) ? 8'h3f : 8'hff;
			v = 8'($urandom);
			wr(7'(IDX_PORT_A + k), v);
			@(negedge pclk);
			cmp_val(32'(port_latch >> (16 - 8 * k)) & 32'(m), 32'(v & m));
			rd(7'(IDX_PORT_A + k), 8'(port_pins >> (16 - 8 * k)) & m);
		end
		$display("test ports done");
		wr(IDX_INTERRUPT_CONTROL, 8'hff);
		wr(IDX_PIR, 8'h3f);
		wr(IDX_STATUS, 8'h27);
		pulse(0);
		rd(IDX_STATUS, 8'h1f);
		rd(IDX_INTERRUPT_CONTROL, 8'h01);
		rd(IDX_PIR, 8'h00);
		rd(IDX_POINTER, 8'h25);
		rd(IDX_TIMER0, 8'h77);
		rd(IDX_PCL, 8'h00);
		wr(IDX_STATUS, 8'h05);
		pulse(1);
		rd(IDX_STATUS, 8'h0d);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_STATUS, 8'h18);
		rd(IDX_INTERRUPT_CONTROL, 8'h00);
		$display("test reset classes done");
		summarize;
	end
endmodule
